// ---- src/link_stats_pkg.sv ----
// Purpose: Shared constants for the link error statistics block
// Assumes: AXI4-Lite register access, 32-bit data, byte addresses
// Notes:   Every counter is held in 16 bits; narrow ones stop at 255
package link_stats_pkg;

   // Counter indices: tributary data link set, then station set
   localparam int IX_INB     = 0;
   localparam int IX_LREP    = 1;
   localparam int IX_RREP    = 2;
   localparam int IX_LBUF    = 3;
   localparam int IX_RBUF    = 4;
   localparam int IX_SELTO   = 5;
   localparam int IX_TXMSG   = 6;
   localparam int IX_RXMSG   = 7;
   localparam int IX_SELINT  = 8;
   localparam int IX_RSTN    = 9;
   localparam int IX_LSTN    = 10;
   localparam int IX_GHDR    = 11;
   localparam int IX_MDAT    = 12;
   localparam int N_LINK     = 9;
   localparam int N_CNT      = 13;

   localparam logic [15:0] MAX8  = 16'h00FF;
   localparam logic [15:0] MAX16 = 16'hFFFF;

   // Background counters are the wide ones
   function automatic logic [15:0] cnt_max(input int i);
      return (i >= IX_TXMSG && i <= IX_SELINT) ? MAX16 : MAX8;
   endfunction : cnt_max

   // Cause flag positions
   localparam int FB_0 = 0;
   localparam int FB_1 = 1;
   localparam int FB_2 = 2;
   localparam int FB_3 = 3;

   // Register map (byte addresses)
   localparam logic [11:0] A_CFG     = 12'h000;
   localparam logic [11:0] A_CMD     = 12'h004;
   localparam logic [1:0]  AREA_LIVE = 2'h1;
   localparam logic [1:0]  AREA_SNAP = 2'h2;
   localparam int          AREA_LSB  = 6;
   localparam int          IDX_LSB   = 2;
   localparam int          FLAG_LSB  = 16;

   localparam int CFG_TYPE_LSB = 0;
   localparam int CFG_OWN_LSB  = 8;
   localparam int CFG_SEL_LSB  = 16;
   localparam logic [31:0] CFG_RESET = 32'h0000_0000;

   localparam int CMD_TRIB_CLR = 0;
   localparam int CMD_STN_CLR  = 1;
   localparam int CMD_MCLR     = 2;

   localparam logic [5:0] NAK_BUF_BUSY  = 6'h08;
   localparam logic [5:0] NAK_OVERRUN   = 6'h09;
   localparam logic [5:0] NAK_TOO_SMALL = 6'h10;
   localparam logic [5:0] NAK_HDR_FMT   = 6'h11;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      ST_P2P_FULL = 2'b00,
      ST_P2P_HALF = 2'b01,
      ST_MP_CTRL  = 2'b10,
      ST_MP_TRIB  = 2'b11
   } station_t;

endpackage : link_stats_pkg

// ---- src/sat_cnt.sv ----
// Purpose: One saturating counter with four sticky cause flags
// Assumes: inc and fset are single-cycle pulses on aclk
// Notes:   A clear taken with an event restarts at that event
module sat_cnt (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        clr,
   input  wire logic        inc,
   input  wire logic [3:0]  fset,
   input  wire logic [15:0] max_val,
   output logic      [15:0] cnt_q,
   output logic      [3:0]  flags_q
);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q <= 16'h0000;
      end else if (clr) begin
         cnt_q <= inc ? 16'h0001 : 16'h0000;
      end else if (inc && cnt_q != max_val) begin
         cnt_q <= cnt_q + 16'h0001;
      end
   end

   // Set wins over clear so no cause is lost
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flags_q <= 4'h0;
      end else if (clr) begin
         flags_q <= fset;
      end else begin
         flags_q <= flags_q | fset;
      end
   end

endmodule : sat_cnt

// ---- src/link_error_stats.sv ----
// Purpose: Error and traffic statistics for a synchronous link controller
// Assumes: Event inputs are one-cycle pulses from logic on aclk
// Notes:   One tributary counter set; each clear snapshots the old values in hardware
// Behaviour
// - Inbound error counter with header, data and reply cause flags
// - Control station charges non-maintenance header errors to selected tributary
// - Count reply requests sent for our unacknowledged data
// - Count acknowledges sent answering a remote reply request
// - Local buffer errors: unavailable and too-small flags on NAK due
// - Remote buffer errors: flags on NAK reasons eight and 16 received
// - Selection timeouts kept only by half-duplex and control stations
// - Timer expiry with no reply evidence sets no-reply flag
// - Timer expiry after reply evidence sets incomplete-reply flag
// - Carrier, sync sequence or lead characters show attempted sending
// - Count transmitted data messages, skip retransmissions, stop at 65535
// - Count good in-sequence received messages, stop at 65535
// - Count messages sent with select flag, selection keepers only
// - Station counters are 8 bits, one set for all tributaries
// - Station counters clear only on master clear or their command
// - Received reason nine NAK counts a remote overrun
// - Header format error counts, flags, and requests reason-17 NAK
// - Control station counts received address not matching selection
// - Babbling or unreleased channel counts and sets streaming flag
// - Local overrun: acknowledged flag with NAK, else silent flag if in header (tributary) or not running (others)
// - Local station counter adds underruns and received reason-17 NAKs
// - Global header and maintenance data check error counters
// - Counters stop at their maximum and never wrap
// - Data link set clears on master clear, establish or its command
module link_error_stats (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [11:0] awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic      [1:0]  bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [11:0] araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic      [31:0] rdata,
   output logic      [1:0]  rresp,
   output logic             rvalid,
   input  wire logic        rready,
   input  wire logic [7:0]  rx_addr,
   input  wire logic        rx_maint,
   input  wire logic        ev_hdr_bcc,
   input  wire logic        ev_nak2_due,
   input  wire logic        ev_nak3_due,
   input  wire logic        ev_rep_sent,
   input  wire logic        ev_ack_rep_sent,
   input  wire logic        ev_nak8_due,
   input  wire logic        ev_nak16_due,
   input  wire logic        ev_nak_rx,
   input  wire logic [5:0]  nak_reason,
   input  wire logic        ev_sel_tx,
   input  wire logic        ev_sel_expire,
   input  wire logic        carrier,
   input  wire logic        ev_sync_rx,
   input  wire logic        ev_lead_char_rx,
   input  wire logic        ev_valid_ctl,
   input  wire logic        ev_valid_hdr,
   input  wire logic        ev_data_tx,
   input  wire logic        tx_retx,
   input  wire logic        ev_data_rx,
   input  wire logic        rx_ok,
   input  wire logic        ev_hdr_fmt,
   input  wire logic        ev_rx_msg,
   input  wire logic        ev_babble,
   input  wire logic        ev_unreleased,
   input  wire logic        ev_rx_overrun,
   input  wire logic        overrun_nak9,
   input  wire logic        rx_in_header,
   input  wire logic        run_state,
   input  wire logic        ev_tx_underrun,
   input  wire logic        ev_maint_data_bcc,
   input  wire logic        ev_trib_establish,
   output logic             nak17_req
);

   localparam int N = link_stats_pkg::N_CNT;

   ////////////////////////////////////////////////////////////////////////
   // Configuration and decode

   logic [31:0]                 cfg_q;
   link_stats_pkg::station_t    st;
   logic [7:0]                  own_addr;
   logic [7:0]                  sel_addr;
   logic                        is_trib;
   logic                        is_ctrl;
   logic                        keeper;
   logic                        hdr_own;
   logic                        hdr_glob;
   logic                        evidence;
   logic                        seen_q;
   logic                        ovr_ack;
   logic                        ovr_sil;
   logic [N-1:0]                inc;
   logic [N-1:0]                clr;
   logic [3:0]                  fset  [N];
   logic [15:0]                 cnt   [N];
   logic [3:0]                  flg   [N];
   logic [19:0]                 snap_q[N];
   logic                        trib_clr;
   logic                        stn_clr;
   logic                        mclr;

   assign st = link_stats_pkg::station_t'(
      cfg_q[link_stats_pkg::CFG_TYPE_LSB +: 2]);
   assign own_addr = cfg_q[link_stats_pkg::CFG_OWN_LSB +: 8];
   assign sel_addr = cfg_q[link_stats_pkg::CFG_SEL_LSB +: 8];
   assign is_trib  = (st == link_stats_pkg::ST_MP_TRIB);
   assign is_ctrl  = (st == link_stats_pkg::ST_MP_CTRL);
   assign keeper   = is_ctrl || st == link_stats_pkg::ST_P2P_HALF;

   // Tributaries only own header errors aimed at them
   assign hdr_own  = ev_hdr_bcc && !rx_maint &&
                     (!is_trib || rx_addr == own_addr);
   assign hdr_glob = ev_hdr_bcc &&
                     (rx_maint || (is_trib && rx_addr != own_addr));

   assign evidence = carrier || ev_sync_rx || ev_lead_char_rx ||
                     ev_valid_ctl || ev_valid_hdr;

   // Reply evidence within the current selection interval
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         seen_q <= 1'b0;
      end else if (evidence) begin
         seen_q <= 1'b1;
      end else if (ev_sel_tx || ev_sel_expire) begin
         seen_q <= 1'b0;
      end
   end

   assign ovr_ack = ev_rx_overrun && overrun_nak9;
   assign ovr_sil = ev_rx_overrun && !overrun_nak9 &&
                    (is_trib ? rx_in_header : !run_state);

   ////////////////////////////////////////////////////////////////////////
   // Events to counters

   always_comb begin
      for (int i = 0; i < N; i++) begin
         fset[i] = 4'h0;
      end
      inc = '0;
      inc[link_stats_pkg::IX_INB] =
         hdr_own || ev_nak2_due || ev_nak3_due;
      fset[link_stats_pkg::IX_INB] =
         {1'b0, ev_nak3_due, ev_nak2_due, hdr_own};
      inc[link_stats_pkg::IX_LREP] = ev_rep_sent;
      inc[link_stats_pkg::IX_RREP] = ev_ack_rep_sent;
      inc[link_stats_pkg::IX_LBUF] = ev_nak8_due || ev_nak16_due;
      fset[link_stats_pkg::IX_LBUF] = {2'b00, ev_nak16_due, ev_nak8_due};
      fset[link_stats_pkg::IX_RBUF] = {2'b00,
         ev_nak_rx && nak_reason == link_stats_pkg::NAK_TOO_SMALL,
         ev_nak_rx && nak_reason == link_stats_pkg::NAK_BUF_BUSY};
      inc[link_stats_pkg::IX_RBUF] = |fset[link_stats_pkg::IX_RBUF];
      if (keeper && ev_sel_expire) begin
         inc[link_stats_pkg::IX_SELTO] = 1'b1;
         fset[link_stats_pkg::IX_SELTO] =
            {2'b00, seen_q || evidence, !(seen_q || evidence)};
      end
      inc[link_stats_pkg::IX_TXMSG] = ev_data_tx && !tx_retx;
      inc[link_stats_pkg::IX_RXMSG] = ev_data_rx && rx_ok;
      inc[link_stats_pkg::IX_SELINT] = keeper && ev_sel_tx;
      fset[link_stats_pkg::IX_RSTN] = {
         ev_babble || ev_unreleased,
         is_ctrl && ev_rx_msg && rx_addr != sel_addr,
         ev_hdr_fmt,
         ev_nak_rx && nak_reason == link_stats_pkg::NAK_OVERRUN};
      inc[link_stats_pkg::IX_RSTN] = |fset[link_stats_pkg::IX_RSTN];
      fset[link_stats_pkg::IX_LSTN] = {
         ev_nak_rx && nak_reason == link_stats_pkg::NAK_HDR_FMT,
         ev_tx_underrun, ovr_sil, ovr_ack};
      inc[link_stats_pkg::IX_LSTN] = |fset[link_stats_pkg::IX_LSTN];
      inc[link_stats_pkg::IX_GHDR] = hdr_glob;
      inc[link_stats_pkg::IX_MDAT] = ev_maint_data_bcc;
   end

   // Header format errors ask the engine for a reason-17 NAK
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         nak17_req <= 1'b0;
      end else begin
         nak17_req <= ev_hdr_fmt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Counter bank and snapshots

   for (genvar g = 0; g < N; g++) begin : g_cnt
      // Station set ignores tributary clears
      assign clr[g] = (g < link_stats_pkg::N_LINK) ? trib_clr : stn_clr;

      sat_cnt u_cnt (
         .aclk    (aclk),
         .aresetn (aresetn),
         .clr     (clr[g]),
         .inc     (inc[g]),
         .fset    (fset[g]),
         .max_val (link_stats_pkg::cnt_max(g)),
         .cnt_q   (cnt[g]),
         .flags_q (flg[g])
      );

      // Snapshot takes the old value in the clearing cycle
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            snap_q[g] <= 20'h00000;
         end else if (clr[g]) begin
            snap_q[g] <= {flg[g], cnt[g]};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite slave

   logic        aw_hold_q;
   logic        w_hold_q;
   logic [11:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0]  wstrb_q;
   logic        aw_hs;
   logic        w_hs;
   logic        have_aw;
   logic        have_w;
   logic        do_wr;
   logic [11:0] wa;
   logic [31:0] wd;
   logic [3:0]  ws;
   logic        bvalid_d;
   logic        rvalid_d;
   logic        ar_hs;
   logic        cmd_wr;
   logic [1:0]  rd_area;
   logic [3:0]  rd_idx;
   logic [31:0] rd_word;
   logic        rd_ok;

   assign aw_hs   = awvalid && awready;
   assign w_hs    = wvalid && wready;
   assign have_aw = aw_hold_q || aw_hs;
   assign have_w  = w_hold_q || w_hs;
   assign do_wr   = have_aw && have_w;
   assign wa      = aw_hold_q ? awaddr_q : awaddr;
   assign wd      = w_hold_q ? wdata_q : wdata;
   assign ws      = w_hold_q ? wstrb_q : wstrb;
   assign bvalid_d = (bvalid && !bready) || do_wr;

   assign cmd_wr   = do_wr && wa == link_stats_pkg::A_CMD && ws[0];
   assign mclr     = cmd_wr && wd[link_stats_pkg::CMD_MCLR];
   assign trib_clr = mclr || ev_trib_establish ||
                     (cmd_wr && wd[link_stats_pkg::CMD_TRIB_CLR]);
   assign stn_clr  = mclr ||
                     (cmd_wr && wd[link_stats_pkg::CMD_STN_CLR]);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_q <= 1'b0;
         w_hold_q  <= 1'b0;
         awready   <= 1'b0;
         wready    <= 1'b0;
         bvalid    <= 1'b0;
         bresp     <= link_stats_pkg::RESP_OKAY;
      end else begin
         aw_hold_q <= have_aw && !do_wr;
         w_hold_q  <= have_w && !do_wr;
         awready   <= !(have_aw && !do_wr) && !bvalid_d;
         wready    <= !(have_w && !do_wr) && !bvalid_d;
         bvalid    <= bvalid_d;
         if (do_wr) begin
            bresp <= (wa == link_stats_pkg::A_CFG ||
                      wa == link_stats_pkg::A_CMD) ?
                     link_stats_pkg::RESP_OKAY : link_stats_pkg::RESP_SLVERR;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awaddr_q <= 12'h000;
         wdata_q  <= 32'h0000_0000;
         wstrb_q  <= 4'h0;
      end else begin
         if (aw_hs) begin
            awaddr_q <= awaddr;
         end
         if (w_hs) begin
            wdata_q <= wdata;
            wstrb_q <= wstrb;
         end
      end
   end

   // Configuration honours byte lanes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg_q <= link_stats_pkg::CFG_RESET;
      end else if (do_wr && wa == link_stats_pkg::A_CFG) begin
         for (int b = 0; b < 4; b++) begin
            if (ws[b]) begin
               cfg_q[8*b +: 8] <= wd[8*b +: 8];
            end
         end
      end
   end

   assign ar_hs    = arvalid && arready;
   assign rvalid_d = (rvalid && !rready) || ar_hs;
   assign rd_area  = araddr[link_stats_pkg::AREA_LSB +: 2];
   assign rd_idx   = araddr[link_stats_pkg::IDX_LSB +: 4];

   always_comb begin
      rd_word = 32'h0000_0000;
      rd_ok   = 1'b1;
      if (araddr == link_stats_pkg::A_CFG) begin
         rd_word = cfg_q;
      end else if (araddr == link_stats_pkg::A_CMD) begin
         rd_word = 32'h0000_0000;
      end else if (araddr[11:8] == 4'h0 && araddr[1:0] == 2'h0 &&
                   32'(rd_idx) < N && rd_area == link_stats_pkg::AREA_LIVE) begin
         rd_word = {12'h000, flg[rd_idx], cnt[rd_idx]};
      end else if (araddr[11:8] == 4'h0 && araddr[1:0] == 2'h0 &&
                   32'(rd_idx) < N && rd_area == link_stats_pkg::AREA_SNAP) begin
         rd_word = {12'h000, snap_q[rd_idx]};
      end else begin
         rd_ok = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rdata   <= 32'h0000_0000;
         rresp   <= link_stats_pkg::RESP_OKAY;
      end else begin
         arready <= !rvalid_d;
         rvalid  <= rvalid_d;
         if (ar_hs) begin
            rdata <= rd_word;
            rresp <= rd_ok ? link_stats_pkg::RESP_OKAY :
                             link_stats_pkg::RESP_SLVERR;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   AST_HDR_CTRL: assert property (
      ev_hdr_bcc && !rx_maint && is_ctrl |=> flg[0][link_stats_pkg::FB_0])
      else $error("Header error not charged to selected tributary");

   AST_SAT_RREP: assert property (
      cnt[2] == link_stats_pkg::MAX8 && !trib_clr |=> $stable(cnt[2]))
      else $error("Remote reply counter left its maximum");

   AST_TX_WIDE: assert property (
      inc[6] && !trib_clr && cnt[6] == 16'h00FF |=> cnt[6] == 16'h0100)
      else $error("Transmit counter did not pass 255");

   AST_RETX: assert property (
      ev_data_tx && tx_retx && !trib_clr |=> $stable(cnt[6]))
      else $error("Retransmission was counted");

   AST_RXBAD: assert property (
      ev_data_rx && !rx_ok && !trib_clr |=> $stable(cnt[7]))
      else $error("Bad received message was counted");

   AST_NOREPLY: assert property (
      ev_sel_expire && keeper && !seen_q && !evidence
      |=> flg[5][link_stats_pkg::FB_0])
      else $error("No-reply flag missing after timer expiry");

   AST_INCOMP: assert property (
      ev_sel_expire && keeper && seen_q
      |=> flg[5][link_stats_pkg::FB_1] && !$stable(cnt[5]) ||
          cnt[5] == link_stats_pkg::MAX8 || $past(trib_clr))
      else $error("Incomplete-reply not recorded");

   AST_SEL_UNUSED: assert property (
      !keeper && !trib_clr |=> $stable(cnt[5]) && $stable(cnt[8]))
      else $error("Selection counters moved on a non-keeper");

   AST_NAK17: assert property (
      ev_hdr_fmt |=> nak17_req ##1 flg[9][link_stats_pkg::FB_1] ||
                     $past(stn_clr))
      else $error("Reason-17 request or flag missing");

   AST_CLR_ATOMIC: assert property (
      trib_clr && inc[0] |=> cnt[0] == 16'h0001 &&
                             snap_q[0][15:0] == $past(cnt[0]))
      else $error("Event lost across read-and-clear");

   AST_STN_KEEP: assert property (
      ev_trib_establish && !stn_clr && !inc[12] |=> $stable(cnt[12]))
      else $error("Station counter cleared by tributary event");

   AST_STICKY: assert property (
      flg[10][link_stats_pkg::FB_2] && !stn_clr
      |=> flg[10][link_stats_pkg::FB_2])
      else $error("Underrun flag dropped without clear");

   COV_SEL_TIMEOUT: cover property (ev_sel_expire && keeper);
   COV_READ_CLEAR:  cover property (trib_clr && |inc);
   COV_SATURATE:    cover property (cnt[2] == link_stats_pkg::MAX8);

endmodule : link_error_stats

// ---- sim/remote_station_model.sv ----
// Purpose: Remote station that sends NAKs and sync sequences on request
// Assumes: Requests are one-cycle pulses launched just after an edge
// Notes:   Reason lines toggle while idle so a stale code shows only on alternate cycles
module remote_station_model (
   input  wire logic       aclk,
   input  wire logic       nak_go,
   input  wire logic [5:0] nak_code,
   input  wire logic       sync_go,
   output logic            ev_nak_rx,
   output logic      [5:0] nak_reason,
   output logic            ev_sync_rx
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      ev_nak_rx  = 1'b0;
      nak_reason = 6'h3F;
      ev_sync_rx = 1'b0;
   end
   always @(posedge aclk) begin
      ev_nak_rx  <= nak_go;
      ev_sync_rx <= sync_go;
      nak_reason <= nak_go ? nak_code : ~nak_reason;
   end
endmodule : remote_station_model

// ---- sim/link_error_statistics_counters_tb.sv ----
// Purpose: Self-checking bench for the link error statistics block
// Assumes: Expected counts and flags are kept in int arrays
// Notes:   Table rows are {event, levels, counter, flag}; -1 means none
module link_error_statistics_counters_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        aclk, aresetn, awvalid, wvalid, arvalid, nak_go, sync_go;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdv;
   logic [7:0]  rx_addr;
   logic [5:0]  nak_code;
   logic [1:0]  rsv;
   logic [21:0] ev;
   logic [6:0]  lv;
   wire         awready, wready, bvalid, arready, rvalid, nak17_req;
   wire         ev_nak_rx, ev_sync_rx;
   wire  [5:0]  nak_reason;
   wire  [1:0]  bresp, rresp;
   wire  [31:0] rdata;
   int          mc[13], mf[13], num_errors, checks_done, k, m;
   int          seed = 32'hD1E6;
   int          tbl[37][4] = '{'{0,0,0,0}, '{1,0,0,1}, '{2,0,0,2},
      '{5,0,3,0}, '{6,0,3,1}, '{108,0,4,0}, '{116,0,4,1}, '{109,0,9,0},
      '{117,0,10,3}, '{7,0,8,-1}, '{8,0,5,0}, '{7,0,8,-1}, '{9,0,-1,0},
      '{8,0,5,1}, '{7,0,8,-1}, '{100,0,-1,0}, '{8,0,5,1}, '{7,0,8,-1},
      '{10,0,-1,0}, '{8,0,5,1}, '{7,0,8,-1}, '{11,0,-1,0}, '{8,0,5,1},
      '{7,1,8,-1}, '{8,1,5,1}, '{13,4,7,-1}, '{13,0,-1,0}, '{15,0,9,2},
      '{16,0,9,3}, '{17,0,9,3}, '{18,16,10,0}, '{18,0,10,1},
      '{18,64,-1,0}, '{19,0,10,2}, '{0,8,11,-1}, '{-1,0,-1,0},
      '{20,0,12,-1}};
   remote_station_model far_u (.*);
   link_error_stats dut_u (.*, .wstrb(4'hF), .bready(1'b1), .rready(1'b1),
      .carrier(lv[0]), .tx_retx(lv[1]), .rx_ok(lv[2]), .rx_maint(lv[3]),
      .overrun_nak9(lv[4]), .rx_in_header(lv[5]), .run_state(lv[6]),
      .ev_hdr_bcc(ev[0]), .ev_nak2_due(ev[1]), .ev_nak3_due(ev[2]),
      .ev_rep_sent(ev[3]), .ev_ack_rep_sent(ev[4]), .ev_nak8_due(ev[5]),
      .ev_nak16_due(ev[6]), .ev_sel_tx(ev[7]), .ev_sel_expire(ev[8]),
      .ev_lead_char_rx(ev[9]), .ev_valid_ctl(ev[10]), .ev_valid_hdr(ev[11]),
      .ev_data_tx(ev[12]), .ev_data_rx(ev[13]), .ev_hdr_fmt(ev[14]),
      .ev_rx_msg(ev[15]), .ev_babble(ev[16]), .ev_unreleased(ev[17]),
      .ev_rx_overrun(ev[18]), .ev_tx_underrun(ev[19]),
      .ev_maint_data_bcc(ev[20]), .ev_trib_establish(ev[21]));
   ////////////////////////////////////////////////////////////////////////
   function automatic void bump(input int i, input int f);
      if (f >= 0) mf[i] |= 1 << f;
      if (mc[i] < ((i >= 6 && i <= 8) ? 65535 : 255)) mc[i]++;
   endfunction : bump
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic rd(input int a);
      araddr  <= 12'(a);
      arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rdv = rdata;
      rsv = rresp;
   endtask : rd
   task automatic wr(input int a, input int d);
      awaddr  <= 12'(a);
      wdata   <= 32'(d);
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      rsv = bresp;
   endtask : wr
   task automatic cmp(input int i);
      rd(64 + 4 * i);
      check(rdv, 32'(mf[i] << 16 | mc[i]));
   endtask : cmp
   task automatic pulse(input int b, input int cnt);
      repeat (cnt) begin
         ev[b] <= 1'b1;
         @(posedge aclk);
         ev <= '0;
         @(posedge aclk);
      end
   endtask : pulse
   // Code 0 asks for a sync sequence instead of a NAK
   task automatic remote(input int r);
      nak_go   <= r > 0;
      sync_go  <= r == 0;
      nak_code <= 6'(r);
      @(posedge aclk);
      nak_go  <= 1'b0;
      sync_go <= 1'b0;
      repeat (2) @(posedge aclk);
   endtask : remote
   // Snapshot must hold the pre-clear value, live copy restarts at zero
   task automatic clr(input int b, input int lo, input int hi);
      if (b < 0) pulse(21, 1);
      else wr(link_stats_pkg::A_CMD, 1 << b);
      for (k = lo; k <= hi; k++) begin
         rd(128 + 4 * k);
         check(rdv, 32'(mf[k] << 16 | mc[k]));
         mc[k] = 0;
         mf[k] = 0;
      end
   endtask : clr
   task automatic end_of_test;
      $display("Checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : end_of_test
   ////////////////////////////////////////////////////////////////////////
   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end
   initial begin
      repeat (20000) @(posedge aclk);
      num_errors++;
      end_of_test();
   end
   initial begin
      {aresetn, awvalid, wvalid, arvalid, nak_go, sync_go, ev, lv} = '0;
      {awaddr, araddr, wdata, nak_code} = '0;
      rx_addr = 8'h33;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      rd(0);
      check(rdv, link_stats_pkg::CFG_RESET);
      wr(0, 32'h0022_1102);
      check(32'(rsv), 32'(link_stats_pkg::RESP_OKAY));
      m = ($random(seed) & 7) + 1;
      pulse(3, m);
      repeat (m) bump(1, -1);
      pulse(4, 260);
      repeat (260) bump(2, -1);
      // Mostly first sends, so the wide count passes 255
      for (m = 0; m < 400; m++) begin
         k = ($random(seed) & 3) == 0;
         lv[1] <= 1'(k);
         pulse(12, 1);
         if (k == 0) bump(6, -1);
      end
      foreach (tbl[r]) begin
         lv <= 7'(tbl[r][1]);
         if (tbl[r][0] >= 100) remote(tbl[r][0] - 100);
         else if (tbl[r][0] >= 0) pulse(tbl[r][0], 1);
         else @(posedge aclk);
         if (tbl[r][2] >= 0) bump(tbl[r][2], tbl[r][3]);
      end
      pulse(14, 1);
      bump(9, 1);
      check(32'(nak17_req), 32'h0000_0001);
      @(posedge aclk);
      check(32'(nak17_req), 32'h0000_0000);
      for (m = 0; m < 13; m++) cmp(m);
      rd(12'h0FC);
      check(rdv, 32'h0000_0000);
      check(32'(rsv), 32'(link_stats_pkg::RESP_SLVERR));
      wr(12'h0FC, 32'h0000_0001);
      check(32'(rsv), 32'(link_stats_pkg::RESP_SLVERR));
      clr(0, 0, 8);
      for (m = 0; m < 13; m++) cmp(m);
      clr(1, 9, 12);
      pulse(3, 2);
      repeat (2) bump(1, -1);
      ev[0] <= 1'b1;
      clr(-1, 0, 8);
      bump(0, 0);
      pulse(19, 1);
      bump(10, 2);
      clr(2, 0, 12);
      wr(0, 32'h0000_0000);
      pulse(7, 1);
      pulse(8, 1);
      for (m = 0; m < 13; m++) cmp(m);
      end_of_test();
   end
endmodule : link_error_statistics_counters_tb
